// ==== design/pm1_pkg.sv ====
package pm1_pkg;
   // register offsets inside the fixed block
   localparam logic [3:0] OFS_ENABLE_HIGH = 4'h3;
   localparam logic [3:0] OFS_CONTROL_LOW = 4'h4;
   localparam logic [3:0] OFS_CONTROL_HIGH = 4'h5;
   localparam logic [3:0] OFS_TIMER_BYTE0 = 4'h8;
   localparam logic [3:0] OFS_TIMER_BYTE1 = 4'h9;
   localparam logic [3:0] OFS_TIMER_BYTE2 = 4'hA;
   // field positions
   localparam int POWER_BUTTON_EVENT_ENABLE_BIT = 0;
   localparam int ALARM_EVENT_ENABLE_BIT = 2;
   localparam int EVENT_ROUTING_MASTER_ENABLE_BIT = 0;
   localparam int BUS_MASTER_WAKE_ENABLE_BIT = 1;
   localparam int GLOBAL_RELEASE_BIT = 2;
   localparam int BUTTON_OVERRIDE_ENABLE_BIT = 1;
   // writable bits, everything else reads zero
   localparam logic [7:0] ENABLE_HIGH_MASK = 8'h05;
   localparam logic [7:0] CONTROL_LOW_MASK = 8'h07;
   localparam logic [7:0] CONTROL_HIGH_MASK = 8'h02;
   localparam logic [7:0] REG_RESET = 8'h00;
   // status flag vector layout
   localparam int FLAG_COUNT = 5;
   localparam int FLAG_POWER_BUTTON = 0;
   localparam int FLAG_ALARM = 1;
   localparam int FLAG_OVERRIDE = 2;
   localparam int FLAG_TIMER = 3;
   localparam int FLAG_FIRMWARE = 4;
   // timer
   localparam int TIMER_WIDTH = 24;
   localparam int TIMER_MSB = 23;
   localparam logic [23:0] TIMER_RESET = 24'h000000;
   localparam logic [31:0] REF_CLK_HZ = 32'd100000000;
   localparam logic [31:0] TIMER_CLK_HZ = 32'd3579545;
   localparam int unsigned OVERRIDE_HOLD_S = 4;
   localparam int unsigned OVERRIDE_TICKS_DEFAULT = OVERRIDE_HOLD_S * 3579545;
   // pin input bundle positions for the synchroniser
   localparam int PIN_COUNT = 6;
   localparam int PIN_BUTTON = 0;
   localparam int PIN_ALARM = 1;
   localparam int PIN_BUS_MASTER = 2;
   localparam int PIN_SLEEP = 3;
   localparam int PIN_OSC_RUNNING = 4;
   localparam int PIN_BUS_RESET = 5;
   typedef enum logic {PWR_SOFT_OFF, PWR_ACTIVE} power_state_type;
endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== design/pm1_control_timer.sv ====
// Behaviour
// R1: button enable gates button flag to SCI/wake
// R2: every button press sets button flag
// R3: alarm enable gates alarm flag to SCI
// R4: every alarm sets alarm flag
// R5: reserved bits read back zero
// R6: master enable gates all SCI sources
// R7: bus master wake from soft off
// R8: wake enable plus bus control raises SCI
// R9: global release sets firmware flag, SMI
// R10: write-one clears release, zero ignored
// R11: four second hold forces soft off
// R12: override clears button flag, sets override
// R13: 24-bit timer counts at 3.579545 MHz working
// R14: low byte read latches upper bytes
// R15: timer zero on either reset
// R16: timer holds while oscillator stopped
// R17: timer msb change sets timer flag
// R18: timer enable routes timer flag to SCI
// R19: registers reset to zero
// R20: flags write-one-clear, hardware set only
// R21: sleeping button event gives wake-up
// R22: SCI is gated OR of enabled flags
// R23: hold counter uses timer clock, restarts
`timescale 1ns/1ps
`default_nettype none
module pm1_control_timer #(
   parameter int unsigned OVERRIDE_TICKS = pm1_pkg::OVERRIDE_TICKS_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [3:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire logic [4:0] flag_clear,
   input wire logic timer_event_enable,
   input wire logic firmware_event_enable,
   input wire logic bus_master_control_bit,
   input wire logic button_in,
   input wire logic alarm_in,
   input wire logic bus_master_request,
   input wire logic sleep_state,
   input wire logic osc_running,
   input wire logic bus_reset_drive,
   output logic [4:0] flags,
   output logic sci,
   output logic smi,
   output logic wake,
   output logic power_on_control_n_o,
   output logic power_on_control_n_oe
);
   logic [pm1_pkg::PIN_COUNT-1:0] pins_s;
   logic [7:0] enable_high_q;
   logic [7:0] control_low_q;
   logic [7:0] control_high_q;
   logic [pm1_pkg::FLAG_COUNT-1:0] flags_q;
   logic [pm1_pkg::FLAG_COUNT-1:0] flag_set;
   logic [pm1_pkg::FLAG_COUNT-1:0] flag_hw_clear;
   logic [23:0] timer_q;
   logic [23:0] timer_d;
   logic [15:0] timer_hold_q;
   logic [31:0] phase_q;
   logic [32:0] phase_sum;
   logic tick;
   logic [31:0] hold_cnt_q;
   logic override_fire;
   logic button_prev_q;
   logic alarm_prev_q;
   logic bm_prev_q;
   logic button_rise;
   logic alarm_rise;
   logic bm_rise;
   logic working;
   logic release_write;
   pm1_pkg::power_state_type state_q;
   pm1_pkg::power_state_type state_d;

   pin_sync #(
      .WIDTH(pm1_pkg::PIN_COUNT)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .async_in({bus_reset_drive, osc_running, sleep_state, bus_master_request, alarm_in, button_in}),
      .sync_out(pins_s)
   );

   function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
      hit = (addr == ofs);
   endfunction

   assign button_rise = pins_s[pm1_pkg::PIN_BUTTON] && !button_prev_q;
   assign alarm_rise = pins_s[pm1_pkg::PIN_ALARM] && !alarm_prev_q;
   assign bm_rise = pins_s[pm1_pkg::PIN_BUS_MASTER] && !bm_prev_q;
   assign working = (state_q == pm1_pkg::PWR_ACTIVE) && !pins_s[pm1_pkg::PIN_SLEEP];
   assign release_write = io_wr && hit(io_addr, pm1_pkg::OFS_CONTROL_LOW)
                          && io_wdata[pm1_pkg::GLOBAL_RELEASE_BIT];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         button_prev_q <= 1'b0;
         alarm_prev_q <= 1'b0;
         bm_prev_q <= 1'b0;
      end else begin
         button_prev_q <= pins_s[pm1_pkg::PIN_BUTTON];
         alarm_prev_q <= pins_s[pm1_pkg::PIN_ALARM];
         bm_prev_q <= pins_s[pm1_pkg::PIN_BUS_MASTER];
      end
   end

   // writable registers, reserved bits never stored
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         enable_high_q <= pm1_pkg::REG_RESET; // R19
         control_low_q <= pm1_pkg::REG_RESET; // R19
         control_high_q <= pm1_pkg::REG_RESET; // R19
      end else begin
         if (io_wr && hit(io_addr, pm1_pkg::OFS_ENABLE_HIGH)) begin
            enable_high_q <= io_wdata & pm1_pkg::ENABLE_HIGH_MASK; // R5
         end
         if (io_wr && hit(io_addr, pm1_pkg::OFS_CONTROL_HIGH)) begin
            control_high_q <= io_wdata & pm1_pkg::CONTROL_HIGH_MASK; // R5
         end
         if (io_wr && hit(io_addr, pm1_pkg::OFS_CONTROL_LOW)) begin
            control_low_q <= io_wdata & pm1_pkg::CONTROL_LOW_MASK; // R5
         end else if (flag_clear[pm1_pkg::FLAG_FIRMWARE]) begin
            control_low_q[pm1_pkg::GLOBAL_RELEASE_BIT] <= 1'b0; // R10
         end
      end
   end

   // fractional divider: 3.579545 MHz tick from the 100 MHz clock
   assign phase_sum = {1'b0, phase_q} + {1'b0, pm1_pkg::TIMER_CLK_HZ};
   assign tick = (phase_sum >= {1'b0, pm1_pkg::REF_CLK_HZ});

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_q <= 32'h00000000;
      end else if (tick) begin
         phase_q <= phase_sum[31:0] - pm1_pkg::REF_CLK_HZ;
      end else begin
         phase_q <= phase_sum[31:0];
      end
   end

   // counts only while working and the reference oscillator runs
   always_comb begin
      timer_d = timer_q;
      if (pins_s[pm1_pkg::PIN_BUS_RESET]) begin
         timer_d = pm1_pkg::TIMER_RESET; // R15
      end else if (tick && working && pins_s[pm1_pkg::PIN_OSC_RUNNING]) begin // R16
         timer_d = timer_q + 24'h000001; // R13
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_q <= pm1_pkg::TIMER_RESET; // R15
      end else begin
         timer_q <= timer_d;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_hold_q <= 16'h0000; // R19
      end else if (pins_s[pm1_pkg::PIN_BUS_RESET]) begin
         timer_hold_q <= 16'h0000; // R19
      end else if (io_rd && hit(io_addr, pm1_pkg::OFS_TIMER_BYTE0)) begin
         timer_hold_q <= timer_q[23:8]; // R14
      end
   end

   // hold counter restarts on release; fires once per press
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_cnt_q <= 32'h00000000;
      end else if (!pins_s[pm1_pkg::PIN_BUTTON]) begin
         hold_cnt_q <= 32'h00000000; // R23
      end else if (tick && hold_cnt_q <= OVERRIDE_TICKS) begin
         hold_cnt_q <= hold_cnt_q + 32'h00000001; // R23
      end
   end

   assign override_fire = tick && pins_s[pm1_pkg::PIN_BUTTON] && (hold_cnt_q == OVERRIDE_TICKS)
                          && control_high_q[pm1_pkg::BUTTON_OVERRIDE_ENABLE_BIT]; // R11

   always_comb begin
      flag_set = '0;
      flag_hw_clear = '0;
      flag_set[pm1_pkg::FLAG_POWER_BUTTON] = button_rise; // R2
      flag_set[pm1_pkg::FLAG_ALARM] = alarm_rise; // R4
      flag_set[pm1_pkg::FLAG_OVERRIDE] = override_fire; // R12
      flag_set[pm1_pkg::FLAG_TIMER] = timer_d[pm1_pkg::TIMER_MSB] != timer_q[pm1_pkg::TIMER_MSB]; // R17
      flag_set[pm1_pkg::FLAG_FIRMWARE] = release_write; // R9
      flag_hw_clear[pm1_pkg::FLAG_POWER_BUTTON] = override_fire; // R12
   end

   // set wins over any clear in the same cycle; zero bits of a clear do nothing
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~(flag_clear | flag_hw_clear)) | flag_set; // R20 R10
      end
   end

   // power-on state: button always wakes, bus master only when allowed
   always_comb begin
      state_d = state_q;
      if (override_fire) begin
         state_d = pm1_pkg::PWR_SOFT_OFF; // R11
      end else if (state_q == pm1_pkg::PWR_SOFT_OFF) begin
         if (button_rise || (bm_rise && control_low_q[pm1_pkg::BUS_MASTER_WAKE_ENABLE_BIT])) begin // R7
            state_d = pm1_pkg::PWR_ACTIVE;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= pm1_pkg::PWR_ACTIVE;
         power_on_control_n_oe <= 1'b1;
         power_on_control_n_o <= 1'b0;
      end else begin
         state_q <= state_d;
         power_on_control_n_oe <= (state_d == pm1_pkg::PWR_ACTIVE); // R7 R11
         power_on_control_n_o <= 1'b0;
      end
   end

   // event outputs, registered so they stand until the flags go
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sci <= 1'b0;
         smi <= 1'b0;
         wake <= 1'b0;
      end else begin
         sci <= control_low_q[pm1_pkg::EVENT_ROUTING_MASTER_ENABLE_BIT] && ( // R6 R22
                   (flags_q[pm1_pkg::FLAG_POWER_BUTTON] && working
                    && enable_high_q[pm1_pkg::POWER_BUTTON_EVENT_ENABLE_BIT]) // R1
                || (flags_q[pm1_pkg::FLAG_ALARM] && enable_high_q[pm1_pkg::ALARM_EVENT_ENABLE_BIT]) // R3
                || (flags_q[pm1_pkg::FLAG_TIMER] && timer_event_enable) // R18
                || (control_low_q[pm1_pkg::BUS_MASTER_WAKE_ENABLE_BIT] && bus_master_control_bit)); // R8
         smi <= flags_q[pm1_pkg::FLAG_FIRMWARE] && firmware_event_enable; // R9
         wake <= !working && flags_q[pm1_pkg::FLAG_POWER_BUTTON]
                 && enable_high_q[pm1_pkg::POWER_BUTTON_EVENT_ENABLE_BIT]; // R21 R1
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags <= '0;
      end else begin
         flags <= (flags_q & ~(flag_clear | flag_hw_clear)) | flag_set;
      end
   end

   // read data registered; unmapped and reserved read as zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         unique case (io_addr)
            pm1_pkg::OFS_ENABLE_HIGH: io_rdata <= enable_high_q; // R5
            pm1_pkg::OFS_CONTROL_LOW: io_rdata <= control_low_q; // R5
            pm1_pkg::OFS_CONTROL_HIGH: io_rdata <= control_high_q; // R5
            pm1_pkg::OFS_TIMER_BYTE0: io_rdata <= timer_q[7:0];
            pm1_pkg::OFS_TIMER_BYTE1: io_rdata <= timer_hold_q[7:0]; // R14
            pm1_pkg::OFS_TIMER_BYTE2: io_rdata <= timer_hold_q[15:8]; // R14
            default: io_rdata <= 8'h00;
         endcase
      end
   end

   a_sci_master_gate: assert property (@(posedge ref_clk) disable iff (!arst_n) // R6
      !control_low_q[pm1_pkg::EVENT_ROUTING_MASTER_ENABLE_BIT] |=> !sci)
      else $error("sci raised with master enable clear");

   a_button_flag_set: assert property (@(posedge ref_clk) disable iff (!arst_n) // R2
      button_rise |=> flags_q[pm1_pkg::FLAG_POWER_BUTTON])
      else $error("button press did not set its flag");

   a_alarm_flag_sci: assert property (@(posedge ref_clk) disable iff (!arst_n) // R3
      (alarm_rise && enable_high_q[pm1_pkg::ALARM_EVENT_ENABLE_BIT]
       && control_low_q[pm1_pkg::EVENT_ROUTING_MASTER_ENABLE_BIT]) |=> ##1 sci)
      else $error("enabled alarm did not raise sci");

   a_release_sets_fw: assert property (@(posedge ref_clk) disable iff (!arst_n) // R9
      release_write |=> flags_q[pm1_pkg::FLAG_FIRMWARE] ##1 (smi == firmware_event_enable))
      else $error("global release did not reach firmware flag or smi");

   a_fw_flag_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
      (flags_q[pm1_pkg::FLAG_FIRMWARE] && !flag_clear[pm1_pkg::FLAG_FIRMWARE])
      |=> flags_q[pm1_pkg::FLAG_FIRMWARE])
      else $error("firmware flag lost without a write of one");

   a_override_off: assert property (@(posedge ref_clk) disable iff (!arst_n) // R11
      override_fire |=> (!power_on_control_n_oe && flags_q[pm1_pkg::FLAG_OVERRIDE]
                         && !flags_q[pm1_pkg::FLAG_POWER_BUTTON]))
      else $error("override did not float power-on or swap flags");

   a_timer_latch: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
      (io_rd && hit(io_addr, pm1_pkg::OFS_TIMER_BYTE0) && !pins_s[pm1_pkg::PIN_BUS_RESET])
      |=> timer_hold_q == $past(timer_q[23:8]))
      else $error("low byte read did not latch upper bytes");

   a_timer_msb_flag: assert property (@(posedge ref_clk) disable iff (!arst_n) // R17
      $changed(timer_q[pm1_pkg::TIMER_MSB]) |-> flags_q[pm1_pkg::FLAG_TIMER])
      else $error("timer msb change missed");

   a_timer_stall: assert property (@(posedge ref_clk) disable iff (!arst_n) // R16
      (!pins_s[pm1_pkg::PIN_OSC_RUNNING] && !pins_s[pm1_pkg::PIN_BUS_RESET]) |=> $stable(timer_q))
      else $error("timer moved with oscillator stopped");

   a_bm_wake: assert property (@(posedge ref_clk) disable iff (!arst_n) // R7
      (state_q == pm1_pkg::PWR_SOFT_OFF && bm_rise && !override_fire
       && !control_low_q[pm1_pkg::BUS_MASTER_WAKE_ENABLE_BIT] && !button_rise)
      |=> !power_on_control_n_oe)
      else $error("bus master woke system while disallowed");

   a_alarm_flag_set: assert property (@(posedge ref_clk) disable iff (!arst_n) // R4
      alarm_rise |=> flags_q[pm1_pkg::FLAG_ALARM])
      else $error("alarm did not set its flag");

   a_wake_gate: assert property (@(posedge ref_clk) disable iff (!arst_n) // R21
      (!working && flags_q[pm1_pkg::FLAG_POWER_BUTTON] && enable_high_q[pm1_pkg::POWER_BUTTON_EVENT_ENABLE_BIT]) |=> wake)
      else $error("sleeping button event gave no wake");

   a_wake_needs_enable: assert property (@(posedge ref_clk) disable iff (!arst_n) // R1
      !enable_high_q[pm1_pkg::POWER_BUTTON_EVENT_ENABLE_BIT] |=> !wake)
      else $error("wake raised with button enable clear");

   a_bus_master_sci: assert property (@(posedge ref_clk) disable iff (!arst_n) // R8
      (control_low_q[pm1_pkg::EVENT_ROUTING_MASTER_ENABLE_BIT] && bus_master_control_bit
       && control_low_q[pm1_pkg::BUS_MASTER_WAKE_ENABLE_BIT]) |=> sci)
      else $error("bus master control did not raise sci");

   a_timer_bus_reset: assert property (@(posedge ref_clk) disable iff (!arst_n) // R15
      pins_s[pm1_pkg::PIN_BUS_RESET] |=> (timer_q == pm1_pkg::TIMER_RESET && timer_hold_q == 16'h0000))
      else $error("bus reset did not zero timer and latch");

   a_smi_gate: assert property (@(posedge ref_clk) disable iff (!arst_n) // R9
      !firmware_event_enable |=> !smi)
      else $error("smi raised with firmware enable clear");
endmodule
`default_nettype wire

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side of the io bus: one-cycle strobes launched just after an edge
module host_model (
   input wire logic ref_clk,
   output logic [3:0] io_addr,
   output logic io_rd,
   output logic io_wr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   initial begin
      io_addr = 4'hF;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 8'h00;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      io_wr = 1'b0;
      // idle bus shows no stale value
      io_addr = ~a;
      io_wdata = ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      io_rd = 1'b0;
      io_addr = ~a;
      d = io_rdata;
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] io_addr;
   logic io_rd, io_wr;
   logic [7:0] io_wdata, io_rdata, v, a, b;
   logic [4:0] flag_clear = 5'h00;
   logic [4:0] flags;
   // timer flag needs 2^23 ticks, so its enable stays set
   logic timer_event_enable = 1'b1;
   logic firmware_event_enable = 1'b1;
   logic bus_master_control_bit = 1'b0;
   logic button_in = 1'b0, alarm_in = 1'b0, bus_master_request = 1'b0;
   logic sleep_state = 1'b0, osc_running = 1'b1, bus_reset_drive = 1'b0;
   logic sci, smi, wake, pon_o, pon_oe;
   int err_count = 0;
   int num_checks = 0;

   always #5 ref_clk = ~ref_clk;

   host_model host (.ref_clk(ref_clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
      .io_wdata(io_wdata), .io_rdata(io_rdata));

   pm1_control_timer #(.OVERRIDE_TICKS(20)) DUT (.ref_clk(ref_clk), .arst_n(arst_n),
      .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .flag_clear(flag_clear), .timer_event_enable(timer_event_enable),
      .firmware_event_enable(firmware_event_enable), .bus_master_control_bit(bus_master_control_bit),
      .button_in(button_in), .alarm_in(alarm_in), .bus_master_request(bus_master_request),
      .sleep_state(sleep_state), .osc_running(osc_running), .bus_reset_drive(bus_reset_drive),
      .flags(flags), .sci(sci), .smi(smi), .wake(wake), .power_on_control_n_o(pon_o),
      .power_on_control_n_oe(pon_oe));

   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic clr(input logic [4:0] m);
      flag_clear = m;
      step(1);
      flag_clear = 5'h00;
      step(3);
   endtask
   task automatic press;
      button_in = 1'b1;
      step(6);
      button_in = 1'b0;
      step(3);
   endtask

   task automatic t_regs;
      chk8({3'h0, flags}, 8'h00);
      chk1(pon_oe, 1'b1);
      host.rd(4'h3, v); chk8(v, 8'h00);
      host.rd(4'h4, v); chk8(v, 8'h00);
      host.rd(4'h5, v); chk8(v, 8'h00);
      host.wr(4'h3, 8'hFF); host.rd(4'h3, v); chk8(v, 8'h05);
      host.wr(4'h5, 8'hFF); host.rd(4'h5, v); chk8(v, 8'h02);
      host.rd(4'h7, v); chk8(v, 8'h00);
      host.wr(4'h5, 8'h00);
      host.wr(4'h3, 8'h00);
   endtask
   task automatic t_release;
      host.wr(4'h4, 8'hFF); step(3);
      host.rd(4'h4, v); chk8(v, 8'h07);
      chk1(flags[4], 1'b1);
      chk1(smi, 1'b1);
      clr(5'h0F); chk1(flags[4], 1'b1);
      clr(5'h10); chk1(smi, 1'b0);
      host.rd(4'h4, v); chk8(v, 8'h03);
      firmware_event_enable = 1'b0;
      host.wr(4'h4, 8'h04); step(3);
      chk1(flags[4], 1'b1);
      chk1(smi, 1'b0);
      clr(5'h10); host.wr(4'h4, 8'h00);
   endtask
   task automatic t_button;
      press; chk1(flags[0], 1'b1);
      chk1(sci, 1'b0);
      host.wr(4'h3, 8'h01); step(3); chk1(sci, 1'b0);
      host.wr(4'h4, 8'h01); step(3); chk1(sci, 1'b1);
      host.wr(4'h3, 8'h00); step(3); chk1(sci, 1'b0);
      host.wr(4'h3, 8'h01);
      clr(5'h01); chk1(sci, 1'b0);
      chk1(flags[0], 1'b0);
   endtask
   task automatic t_alarm;
      host.wr(4'h3, 8'h00);
      alarm_in = 1'b1; step(6); alarm_in = 1'b0; step(3);
      chk1(flags[1], 1'b1);
      chk1(sci, 1'b0);
      host.wr(4'h3, 8'h04); step(3); chk1(sci, 1'b1);
      clr(5'h02); chk1(sci, 1'b0);
      alarm_in = 1'b1; step(6); alarm_in = 1'b0; step(3);
      chk1(sci, 1'b1);
      clr(5'h02); chk1(flags[1], 1'b0);
   endtask
   task automatic t_wake;
      sleep_state = 1'b1;
      host.wr(4'h3, 8'h01); press;
      chk1(wake, 1'b1);
      chk1(sci, 1'b0);
      clr(5'h01); sleep_state = 1'b0; step(4);
      chk1(wake, 1'b0);
      host.wr(4'h4, 8'h00);
   endtask
   task automatic t_timer;
      bus_reset_drive = 1'b1; step(4); bus_reset_drive = 1'b0; step(3);
      host.rd(4'h8, v); chk1(v <= 8'h02, 1'b1);
      step(560);
      host.rd(4'h8, v); chk1(v >= 8'h12 && v <= 8'h16, 1'b1);
      step(6700);
      host.rd(4'h8, v); host.rd(4'h9, v); chk8(v, 8'h01);
      host.rd(4'hA, v); chk8(v, 8'h00);
      osc_running = 1'b0; step(4);
      host.rd(4'h8, a); step(100); host.rd(4'h8, b); chk8(b, a);
      osc_running = 1'b1; step(100);
      host.rd(4'h8, b); v = b - a; chk1(v >= 8'h02 && v <= 8'h05, 1'b1);
   endtask
   task automatic t_override;
      int n = 0;
      clr(5'h1F);
      host.wr(4'h5, 8'h02);
      button_in = 1'b1; step(300); chk1(pon_oe, 1'b1);
      while (pon_oe !== 1'b0 && n < 3000) begin
         step(1);
         n++;
      end
      if (n == 3000) begin
         err_count++;
         end_sim();
      end
      chk1(flags[2], 1'b1);
      chk1(flags[0], 1'b0);
      button_in = 1'b0; step(4); chk1(pon_oe, 1'b0);
      host.rd(4'h8, a); step(100); host.rd(4'h8, b); chk8(b, a);
      bus_master_request = 1'b1; step(6); bus_master_request = 1'b0;
      chk1(pon_oe, 1'b0);
      clr(5'h1F); host.wr(4'h4, 8'h03); bus_master_control_bit = 1'b1; step(3);
      chk1(sci, 1'b1);
      bus_master_request = 1'b1; step(6); chk1(pon_oe, 1'b1);
      chk1(pon_o, 1'b0);
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      step(1);
      t_regs();
      t_release();
      t_button();
      t_alarm();
      t_wake();
      t_timer();
      t_override();
      end_sim();
   end
endmodule
`default_nettype wire
